// file: css_partner.sv
/*
  Behavioural supply rail, comparators and current sense.
  Assumes the bench steers external supply, power-down and trip time.
*/
`timescale 1ns/1ps
module css_partner (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       src_en_i,
  input  wire logic [1:0] src_level_i,
  input  wire logic       gate_i,
  input  wire logic       ext_i,
  input  wire logic       drop_i,
  input  wire logic [9:0] trip_cyc_i,
  output logic            low_o,
  output logic            start_o,
  output logic            rearm_o,
  output logic            uvlo_o,
  output logic            trip_o
);
  int rail;
  int on_t;

  // Rail in mV; charge rate per code, else drain 1 per cycle, 8 with drop_i
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rail <= 0;
      on_t <= 0;
    end else begin
      on_t <= gate_i ? on_t + 1 : 0;
      if (ext_i)
        rail <= 8500;
      else if (src_en_i)
        rail <= rail + (src_level_i == 2'h0 ? 4 :
                        src_level_i == 2'h1 ? 16 : 24);
      else
        rail <= (rail > 8) ? rail - (drop_i ? 8 : 1) : 0;
    end
  end

  // Comparators; trip code 0 means sense never trips
  assign low_o   = rail > 1000;
  assign start_o = rail >= 8000;
  assign rearm_o = rail > 4250;
  assign uvlo_o  = rail > 4000;
  assign trip_o  = gate_i && trip_cyc_i != 10'h0 && on_t >= trip_cyc_i;
endmodule : css_partner

// file: css_pkg.sv
/*
  Shared constants for the converter start-up and soft-start sequencer:
  clock rate, timing counts, switching periods, jitter and charge codes.
  Assumes a single 50 MHz clock for every file that uses it.
*/
package css_pkg;

  // Clock
  localparam int unsigned CLK_HZ       = 50_000_000;

  // Soft-start: total time in ms and number of equal steps
  localparam int unsigned SS_TIME_MS   = 8;
  localparam int unsigned SS_STEPS     = 8;
  localparam int unsigned SS_STEP_CYC  =
    CLK_HZ / 1000 * SS_TIME_MS / SS_STEPS;
  // Limit step size of 50 mA is applied by the analog DAC
  localparam logic [3:0]  SS_FULL      = 4'h8;

  // Restart delay after a fault, in seconds
  localparam int unsigned RESTART_S    = 1;
  localparam int unsigned RESTART_CYC  = CLK_HZ * RESTART_S;

  // Wake debounce, in microseconds; wake needs strictly longer
  localparam int unsigned WAKE_DEB_US  = 20;
  localparam int unsigned WAKE_DEB_CYC = CLK_HZ / 1_000_000 * WAKE_DEB_US;

  // Timer width covers the longest count
  localparam int unsigned TMR_W        = 26;

  // Switching frequency options and periods in clock cycles
  localparam int unsigned FSW_LO_HZ    = 60_000;
  localparam int unsigned FSW_HI_HZ    = 120_000;
  localparam int unsigned PER_W        = 10;
  localparam logic [PER_W-1:0] PER_LO  = PER_W'(CLK_HZ / FSW_LO_HZ);
  localparam logic [PER_W-1:0] PER_HI  = PER_W'(CLK_HZ / FSW_HI_HZ);

  // Jitter: +-7 % swept in a triangle at 260 Hz over +-8 positions
  localparam int unsigned JIT_PCT      = 7;
  localparam int unsigned JIT_POS      = 8;
  localparam logic [PER_W-1:0] JIT_STEP_LO =
    PER_W'(CLK_HZ / FSW_LO_HZ * JIT_PCT / 100 / JIT_POS);
  localparam logic [PER_W-1:0] JIT_STEP_HI =
    PER_W'(CLK_HZ / FSW_HI_HZ * JIT_PCT / 100 / JIT_POS);
  localparam int unsigned MOD_HZ       = 260;
  localparam int unsigned MOD_TICK_CYC = CLK_HZ / MOD_HZ / (4 * JIT_POS);

  // Duty cycle ceiling, inside the 70..80 % window
  localparam int unsigned DUTY_MAX_PCT = 75;

  // Charge source current level codes (1, 3.2, 7.8 mA in the analog)
  localparam logic [1:0]  SRC_INITIAL  = 2'h0;
  localparam logic [1:0]  SRC_FAST     = 2'h1;
  localparam logic [1:0]  SRC_RECHARGE = 2'h2;

  // Supply sequencing states
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_CHARGE  = 3'b001,
    ST_RUN     = 3'b010,
    ST_RESTART = 3'b011,
    ST_IDLE    = 3'b100
  } css_state_type;

endpackage : css_pkg

// file: css_seq.sv
/*
  Converter start-up supply sequencer, soft-start and gate control.
  Assumes comparator flags and strap inputs synchronous to clk_i.
*/
// Function
// - Enable charging source once drain comparator reports startup threshold.
// - Use initial low charge current while supply rail is near zero.
// - Switch to fast charge current once rail passes low threshold.
// - At start level begin operating, allow switching, disable source.
// - Self-supply: recharge at re-arm level until start level regained.
// - Recharge current only during the switch off interval.
// - Keep source off while external supply holds rail above re-arm.
// - Low drain at power-down: source off, stop below lockout level.
// - Soft-start raises peak limit from zero to full in eight steps.
// - Soft-start ramp lasts 8 ms with evenly spread steps.
// - Run soft-start at every start-up attempt and automatic restart.
// - Jitter switching frequency about seven percent at 260 Hz.
// - Nominal frequency selectable between 60 kHz and 120 kHz.
// - Leave zero-power idle only after wake held low over 20 us.
// - After fault wait restart delay, then restart with soft-start.
`timescale 1ns/1ps
module css_seq #(
  parameter int unsigned SS_STEP_CYC = css_pkg::SS_STEP_CYC,
  parameter int unsigned RESTART_CYC = css_pkg::RESTART_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       drain_ok_i,
  input  wire logic       vcc_above_low_i,
  input  wire logic       vcc_above_start_i,
  input  wire logic       vcc_above_rearm_i,
  input  wire logic       vcc_above_uvlo_i,
  input  wire logic       fault_i,
  input  wire logic       idle_req_i,
  input  wire logic       wake_low_i,
  input  wire logic       current_trip_i,
  input  wire logic       freq_hi_i,
  output logic            src_en_o,
  output logic [1:0]      src_level_o,
  output logic            gate_o,
  output logic [3:0]      ilim_step_o,
  output logic            run_o,
  output logic            idle_o
);

  css_pkg::css_state_type        state_reg, state_next;
  logic [css_pkg::TMR_W-1:0]     tmr_reg, tmr_next;
  logic [3:0]                    step_reg, step_next;
  logic                          rchg_reg, rchg_next;
  logic                          gate_reg, gate_next;
  logic                          src_reg, src_next;
  logic [1:0]                    lvl_reg, lvl_next;
  logic                          run_reg, run_next;
  logic                          idle_reg, idle_next;
  logic                          fhi_reg, fhi_next;

  css_tb_if tbi ();

  assign tbi.enable  = (state_reg == css_pkg::ST_RUN);
  assign tbi.freq_hi = fhi_reg;

  css_timebase u_timebase (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .tb     (tbi)
  );

  assign src_en_o    = src_reg;
  assign src_level_o = lvl_reg;
  assign gate_o      = gate_reg;
  assign ilim_step_o = step_reg;
  assign run_o       = run_reg;
  assign idle_o      = idle_reg;

  // Timer terminal count for a given length
  function automatic logic tmr_done(
    input logic [css_pkg::TMR_W-1:0] t,
    input int unsigned               len);
    return t >= css_pkg::TMR_W'(len - 1);
  endfunction : tmr_done

  // Sequencer next state; one timer serves each state in turn
  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_reg + 1'b1;
    step_next  = step_reg;
    rchg_next  = rchg_reg;
    gate_next  = gate_reg;
    src_next   = 1'b0;
    lvl_next   = lvl_reg;
    fhi_next   = fhi_reg;
    case (state_reg)
      css_pkg::ST_OFF: begin
        tmr_next  = '0;
        step_next = 4'h0;
        rchg_next = 1'b0;
        gate_next = 1'b0;
        // Option strap is caught while off, never at reset
        fhi_next  = freq_hi_i;
        if (drain_ok_i) begin
          state_next = css_pkg::ST_CHARGE;
        end
      end
      css_pkg::ST_CHARGE: begin
        tmr_next  = '0;
        step_next = 4'h0;
        gate_next = 1'b0;
        src_next  = drain_ok_i;
        lvl_next  = vcc_above_low_i ? css_pkg::SRC_FAST
                                    : css_pkg::SRC_INITIAL;
        if (vcc_above_start_i) begin
          state_next = css_pkg::ST_RUN;
          src_next   = 1'b0;
          rchg_next  = 1'b0;
        end else if (!drain_ok_i) begin
          state_next = css_pkg::ST_OFF;
        end
      end
      css_pkg::ST_RUN: begin
        if (tmr_done(tmr_reg, SS_STEP_CYC)) begin
          tmr_next = '0;
          if (step_reg != css_pkg::SS_FULL) begin
            step_next = step_reg + 4'h1;
          end
        end
        if (step_reg == css_pkg::SS_FULL) begin
          tmr_next = '0; // Hold timer once ramp is done
        end
        if (!vcc_above_rearm_i) begin
          rchg_next = 1'b1;
        end else if (vcc_above_start_i) begin
          rchg_next = 1'b0;
        end
        lvl_next = css_pkg::SRC_RECHARGE;
        if (tbi.on_limit || current_trip_i) begin
          gate_next = 1'b0;
        end else if (tbi.cycle_start && step_reg != 4'h0) begin
          gate_next = 1'b1;
        end
        // recharge only in off interval
        // Next gate value, so source and switch never overlap
        src_next = rchg_reg && !gate_next && drain_ok_i;
        if (!vcc_above_uvlo_i) begin
          state_next = css_pkg::ST_OFF;
          src_next   = 1'b0;
          gate_next  = 1'b0;
        end else if (fault_i) begin
          state_next = css_pkg::ST_RESTART;
          tmr_next   = '0;
          src_next   = 1'b0;
          gate_next  = 1'b0;
        end else if (idle_req_i) begin
          state_next = css_pkg::ST_IDLE;
          tmr_next   = '0;
          src_next   = 1'b0;
          gate_next  = 1'b0;
        end
      end
      css_pkg::ST_RESTART: begin
        gate_next = 1'b0;
        step_next = 4'h0;
        if (tmr_done(tmr_reg, RESTART_CYC)) begin
          state_next = css_pkg::ST_CHARGE;
          tmr_next   = '0;
        end
      end
      css_pkg::ST_IDLE: begin
        gate_next = 1'b0;
        step_next = 4'h0;
        // wake needs held low over debounce
        if (!wake_low_i) begin
          tmr_next = '0;
        end else if (tmr_reg >= css_pkg::TMR_W'(css_pkg::WAKE_DEB_CYC)) begin
          state_next = css_pkg::ST_CHARGE;
          tmr_next   = '0;
        end
      end
      default: begin
        state_next = css_pkg::ST_OFF;
        tmr_next   = '0;
        gate_next  = 1'b0;
      end
    endcase
    run_next  = (state_next == css_pkg::ST_RUN);
    idle_next = (state_next == css_pkg::ST_IDLE);
  end

  // Register sequencer state and outputs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= css_pkg::ST_OFF;
      tmr_reg   <= '0;
      step_reg  <= 4'h0;
      rchg_reg  <= 1'b0;
      gate_reg  <= 1'b0;
      src_reg   <= 1'b0;
      lvl_reg   <= css_pkg::SRC_INITIAL;
      run_reg   <= 1'b0;
      idle_reg  <= 1'b0;
      fhi_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
      step_reg  <= step_next;
      rchg_reg  <= rchg_next;
      gate_reg  <= gate_next;
      src_reg   <= src_next;
      lvl_reg   <= lvl_next;
      run_reg   <= run_next;
      idle_reg  <= idle_next;
      fhi_reg   <= fhi_next;
    end
  end

endmodule : css_seq

// file: css_seq_properties.sv
/*
  Concurrent checks on the sequencer ports.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module css_seq_props #(
  parameter int unsigned SS_STEP_CYC = 20,
  parameter int unsigned RESTART_CYC = 50
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       drain_ok_i,
  input wire logic       vcc_above_low_i,
  input wire logic       vcc_above_rearm_i,
  input wire logic       vcc_above_uvlo_i,
  input wire logic       vcc_above_start_i,
  input wire logic       fault_i,
  input wire logic       wake_low_i,
  input wire logic       src_en_o,
  input wire logic [1:0] src_level_o,
  input wire logic       gate_o,
  input wire logic [3:0] ilim_step_o,
  input wire logic       run_o,
  input wire logic       idle_o
);
  localparam int MAX_ON =
    (int'(css_pkg::PER_LO) + 8 * int'(css_pkg::JIT_STEP_LO)) * 80 / 100;
  logic [15:0] on_cnt_reg;
  logic [15:0] wake_cnt_reg;
  logic        low_seen_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Helper counts: on-time, wake hold, rail dip since start
  always_ff @(posedge clk_i) begin
    on_cnt_reg   <= gate_o ? on_cnt_reg + 16'h1 : 16'h0;
    wake_cnt_reg <= (idle_o && wake_low_i) ? wake_cnt_reg + 16'h1 : 16'h0;
    if (!run_o || vcc_above_start_i)
      low_seen_reg <= 1'b0;
    else if (!vcc_above_rearm_i)
      low_seen_reg <= 1'b1;
  end

  a_src_needs_drain: assert property (
    src_en_o |-> $past(drain_ok_i)) else $error("source on without drain");
  a_charge_level: assert property (
    src_en_o && !run_o |-> src_level_o == ($past(vcc_above_low_i) ?
      css_pkg::SRC_FAST : css_pkg::SRC_INITIAL))
    else $error("wrong charge level");
  a_start_clean: assert property (
    $rose(run_o) |-> !src_en_o && !gate_o && ilim_step_o == 4'h0)
    else $error("bad start state");
  a_recharge_level: assert property (
    run_o && src_en_o |-> src_level_o == css_pkg::SRC_RECHARGE)
    else $error("wrong recharge level");
  a_off_only: assert property (
    src_en_o |-> !gate_o) else $error("source on during on-time");
  a_ext_quiet: assert property (
    run_o && !low_seen_reg && !$past(low_seen_reg) |-> !src_en_o)
    else $error("source on above rearm");
  a_uvlo_stop: assert property (
    run_o && !vcc_above_uvlo_i |=> !run_o && !src_en_o && !gate_o)
    else $error("no stop at lockout");
  a_step_plus_one: assert property (
    run_o && $past(run_o) && $changed(ilim_step_o) |->
      ilim_step_o == $past(ilim_step_o) + 4'h1 && ilim_step_o <= 4'h8)
    else $error("bad soft-start step");
  a_step_spacing: assert property (
    run_o && ($rose(run_o) || $changed(ilim_step_o)) && ilim_step_o != 4'h8
    |-> ##SS_STEP_CYC (!run_o || ilim_step_o == $past(ilim_step_o) + 4'h1))
    else $error("soft-start step spacing");
  a_duty_ceiling: assert property (
    gate_o |-> on_cnt_reg < MAX_ON) else $error("on-time too long");
  a_wake_debounce: assert property (
    $fell(idle_o) |-> wake_cnt_reg > css_pkg::WAKE_DEB_CYC)
    else $error("idle left too early");
  a_restart_wait: assert property (
    run_o && fault_i && vcc_above_uvlo_i |-> ##RESTART_CYC
      (!run_o && !src_en_o) ##[1:5] (run_o || src_en_o))
    else $error("restart timing");
endmodule : css_seq_props

// file: css_tb_if.sv
/*
  Interface between the sequencer and its switching timebase.
  Assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ps
interface css_tb_if;
  logic enable;       // Timebase runs while set
  logic freq_hi;      // High-frequency option strap
  logic cycle_start;  // One-cycle pulse at each period start
  logic on_limit;     // One-cycle pulse at the duty ceiling

  modport tb  (input enable, input freq_hi,
               output cycle_start, output on_limit);
  modport ctl (output enable, output freq_hi,
               input cycle_start, input on_limit);
endinterface : css_tb_if

// file: css_timebase.sv
/*
  Jittered switching timebase with duty cycle ceiling.
  Assumes the 50 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module css_timebase (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  css_tb_if.tb      tb
);

  logic [css_pkg::PER_W-1:0] cnt_reg, cnt_next;
  logic [css_pkg::PER_W-1:0] per_reg, per_next;
  logic [css_pkg::PER_W-1:0] ceil_reg, ceil_next;
  logic signed [4:0]         pos_reg, pos_next;
  logic                      up_reg, up_next;
  logic [12:0]               mtk_reg, mtk_next;
  logic                      start_reg, start_next;
  logic                      lim_reg, lim_next;
  logic [css_pkg::PER_W-1:0] nom;
  logic [css_pkg::PER_W-1:0] stp;
  logic [css_pkg::PER_W-1:0] newp;
  logic [16:0]               prod;

  assign tb.cycle_start = start_reg;
  assign tb.on_limit    = lim_reg;

  // Period counter, jitter sweep and ceiling
  always_comb begin
    nom  = tb.freq_hi ? css_pkg::PER_HI : css_pkg::PER_LO;
    stp  = tb.freq_hi ? css_pkg::JIT_STEP_HI : css_pkg::JIT_STEP_LO;
    newp = PER_W_ADD(nom, stp, pos_reg);
    prod = 17'(newp) * 17'(css_pkg::DUTY_MAX_PCT);
    cnt_next   = cnt_reg + 1'b1;
    per_next   = per_reg;
    ceil_next  = ceil_reg;
    start_next = 1'b0;
    lim_next   = 1'b0;
    pos_next   = pos_reg;
    up_next    = up_reg;
    mtk_next   = mtk_reg + 1'b1;
    if (mtk_reg == 13'(css_pkg::MOD_TICK_CYC - 1)) begin
      mtk_next = 13'h0000;
      if (up_reg) begin
        pos_next = pos_reg + 5'sd1;
        up_next  = (pos_reg != 5'(css_pkg::JIT_POS - 1));
      end else begin
        pos_next = pos_reg - 5'sd1;
        up_next  = (pos_reg == -5'(css_pkg::JIT_POS - 1));
      end
    end
    if (cnt_reg >= per_reg - 1'b1) begin
      cnt_next   = '0;
      start_next = 1'b1;
      per_next   = newp;
      ceil_next  = PER_W_CUT(prod / 17'd100);
    end
    if (cnt_reg == ceil_reg) begin
      lim_next = 1'b1;
    end
    if (!tb.enable) begin
      cnt_next   = '0;
      per_next   = nom;
      ceil_next  = PER_W_CUT(17'(nom) * 17'(css_pkg::DUTY_MAX_PCT)
                             / 17'd100);
      start_next = 1'b0;
      lim_next   = 1'b0;
    end
  end

  // Register the timebase state
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg   <= '0;
      per_reg   <= css_pkg::PER_LO;
      ceil_reg  <= '0;
      pos_reg   <= 5'sd0;
      up_reg    <= 1'b1;
      mtk_reg   <= 13'h0000;
      start_reg <= 1'b0;
      lim_reg   <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      per_reg   <= per_next;
      ceil_reg  <= ceil_next;
      pos_reg   <= pos_next;
      up_reg    <= up_next;
      mtk_reg   <= mtk_next;
      start_reg <= start_next;
      lim_reg   <= lim_next;
    end
  end

  // Nominal period plus signed jitter offset
  function automatic logic [css_pkg::PER_W-1:0] PER_W_ADD(
    input logic [css_pkg::PER_W-1:0] n,
    input logic [css_pkg::PER_W-1:0] s,
    input logic signed [4:0]         p);
    logic signed [15:0] t;
    t = signed'(16'(n)) + signed'(16'(s)) * 16'(p);
    return t[css_pkg::PER_W-1:0];
  endfunction : PER_W_ADD

  // Trim a product down to period width
  function automatic logic [css_pkg::PER_W-1:0] PER_W_CUT(
    input logic [16:0] v);
    return v[css_pkg::PER_W-1:0];
  endfunction : PER_W_CUT

endmodule : css_timebase

// file: tb_css_seq.sv
/*
  Self-checking bench for the sequencer with the rail model.
  Assumes short soft-start and restart counts set below.
*/
`timescale 1ns/1ps
module tb_css_seq;
  localparam int SS = 20;
  localparam int RS = 50;
  logic       clk_i, nrst_i, drain_ok, fault, idle_req, wake_low, freq_hi;
  logic       v_low, v_start, v_rearm, v_uvlo, trip, ext, drop;
  logic       src_en, gate, run, idle;
  logic [1:0] src_level;
  logic [3:0] ilim;
  logic [9:0] trip_cyc;
  int         error_cnt, n_tests, pmin, pmax, last, ton, tmax, nsrc;

  css_seq #(.SS_STEP_CYC(SS), .RESTART_CYC(RS)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .drain_ok_i(drain_ok),
    .vcc_above_low_i(v_low), .vcc_above_start_i(v_start),
    .vcc_above_rearm_i(v_rearm), .vcc_above_uvlo_i(v_uvlo),
    .fault_i(fault), .idle_req_i(idle_req), .wake_low_i(wake_low),
    .current_trip_i(trip), .freq_hi_i(freq_hi), .src_en_o(src_en),
    .src_level_o(src_level), .gate_o(gate), .ilim_step_o(ilim),
    .run_o(run), .idle_o(idle));
  css_partner u_part (
    .clk_i(clk_i), .nrst_i(nrst_i), .src_en_i(src_en),
    .src_level_i(src_level), .gate_i(gate), .ext_i(ext), .drop_i(drop),
    .trip_cyc_i(trip_cyc), .low_o(v_low), .start_o(v_start),
    .rearm_o(v_rearm), .uvlo_o(v_uvlo), .trip_o(trip));

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait on an output, sampled at the falling edge
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && s !== v; i++) @(negedge clk_i);
    chk(s, v);
  endtask : wait_for

  // Period spread and on-time with the sense never tripping
  task automatic measure(input int n, input int per, input int js);
    int i;
    pmin = 99999;
    pmax = 0;
    last = 0;
    tmax = 0;
    nsrc = 0;
    // A pulse already high at the start is no rising edge
    ton = (gate === 1'b1) ? 1 : 0;
    for (i = 1; i <= n; i++) begin
      @(negedge clk_i);
      if (gate === 1'b1 && ton == 0) begin
        if (last > 0) pmin = (i - last < pmin) ? i - last : pmin;
        if (last > 0) pmax = (i - last > pmax) ? i - last : pmax;
        last = i;
      end
      ton = (gate === 1'b1) ? ton + 1 : 0;
      tmax = (ton > tmax) ? ton : tmax;
      if (src_en === 1'b1) nsrc++;
    end
    chk(pmin >= per - 8 * js && pmax <= per + 8 * js, 1'b1);
    chk(pmax > pmin, 1'b1);
    chk(tmax * 100 >= 70 * pmin && tmax * 100 <= 80 * pmax, 1'b1);
    chk(nsrc > 0, 1'b1);
  endtask : measure

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(57298));
    {nrst_i, drain_ok, fault, idle_req, wake_low, freq_hi} = 6'h0;
    {ext, drop, ton, error_cnt, n_tests} = 0;
    trip_cyc = 10'h0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    drain_ok <= 1'b1;
    wait_for(run, 1'b1, 3000);
    repeat (8 * SS - 2) @(negedge clk_i);
    chk(ilim, 4'h7);
    repeat (4) @(negedge clk_i);
    chk(ilim, css_pkg::SS_FULL);
    measure(14000, css_pkg::PER_LO, css_pkg::JIT_STEP_LO);
    @(posedge clk_i);
    ext <= 1'b1;
    trip_cyc <= 10'(50 + $urandom % 300);
    repeat (10) @(negedge clk_i);
    nsrc = 0;
    repeat (3000) begin
      @(negedge clk_i);
      if (src_en !== 1'b0) nsrc++;
    end
    chk(nsrc, 0);
    ext <= 1'b0;
    @(posedge clk_i);
    fault <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
    @(negedge clk_i);
    chk(run, 1'b0);
    wait_for(run, 1'b1, RS + 1000);
    @(posedge clk_i);
    idle_req <= 1'b1;
    @(posedge clk_i);
    idle_req <= 1'b0;
    wait_for(idle, 1'b1, 10);
    @(posedge clk_i);
    wake_low <= 1'b1;
    repeat (css_pkg::WAKE_DEB_CYC) @(posedge clk_i);
    wake_low <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk(idle, 1'b1);
    @(posedge clk_i);
    wake_low <= 1'b1;
    repeat (css_pkg::WAKE_DEB_CYC + 1 + $urandom % 50) @(posedge clk_i);
    wake_low <= 1'b0;
    wait_for(idle, 1'b0, 5);
    wait_for(run, 1'b1, 3000);
    @(posedge clk_i);
    drain_ok <= 1'b0;
    drop <= 1'b1;
    wait_for(run, 1'b0, 5000);
    chk(src_en, 1'b0);
    @(posedge clk_i);
    {drop, freq_hi} <= 2'h1;
    trip_cyc <= 10'h0;
    @(posedge clk_i);
    drain_ok <= 1'b1;
    wait_for(run, 1'b1, 3000);
    measure(8000, css_pkg::PER_HI, css_pkg::JIT_STEP_HI);
    tally_and_finish();
  end
endmodule : tb_css_seq

bind css_seq css_seq_props #(.SS_STEP_CYC(SS_STEP_CYC),
  .RESTART_CYC(RESTART_CYC)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .drain_ok_i(drain_ok_i),
  .vcc_above_low_i(vcc_above_low_i), .vcc_above_rearm_i(vcc_above_rearm_i),
  .vcc_above_uvlo_i(vcc_above_uvlo_i),
  .vcc_above_start_i(vcc_above_start_i), .fault_i(fault_i),
  .wake_low_i(wake_low_i), .src_en_o(src_en_o), .src_level_o(src_level_o),
  .gate_o(gate_o), .ilim_step_o(ilim_step_o), .run_o(run_o),
  .idle_o(idle_o));
